// file: cism_map.vh
`ifndef CISM_MAP_VH
`define CISM_MAP_VH

// register indices; the bus byte address is four times the index
`define CISM_IDX_FLAGS1 14'h0730
`define CISM_IDX_FLAGS2 14'h0731
`define CISM_IDX_LIVE2 14'h0732
`define CISM_IDX_MASK1 14'h0738
`define CISM_IDX_MASK2 14'h0739
`define CISM_IDX_CTRL 14'h0740

// first event group bit positions
`define CISM_B1_PIN11 10
`define CISM_B1_PIN10 9
`define CISM_B1_PIN9 8
`define CISM_B1_PIN8 7
`define CISM_B1_JACK 5
`define CISM_B1_PIN1 0

// second event group and live status bit positions
`define CISM_B2_TWARN 15
`define CISM_B2_SERVO 14
`define CISM_B2_FIFO 12
`define CISM_B2_DRC2 11
`define CISM_B2_DRC1 9
`define CISM_B2_SRC2 8
`define CISM_B2_SRC1 7
`define CISM_B2_FLL2 6
`define CISM_B2_FLL1 5
`define CISM_B2_MIC 1
`define CISM_B2_TSHUT 0

// control register bit position
`define CISM_BC_REQ_MASK 0

// implemented bits, edge selection, writable bits and reset values
`define CISM_FLAGS1_IMPL 16'h07a1
`define CISM_FLAGS1_BOTH 16'h07a1
`define CISM_FLAGS2_IMPL 16'hdbe3
`define CISM_FLAGS2_BOTH 16'h81e3
`define CISM_LIVE2_IMPL 16'hdbe1
`define CISM_MASK1_WR 16'h07a1
`define CISM_MASK1_RST 16'h07ff
`define CISM_MASK2_WR 16'hdbe3
`define CISM_MASK2_RST 16'hdbe3
`define CISM_CTRL_WR 16'h0001
`define CISM_CTRL_RST 16'h0000
`define CISM_FLAGS_RST 16'h0000

`endif

// file: cism_field_reg.v
`timescale 1ns/10ps
// read/write register; bits outside the writable mask keep their reset value
module cism_field_reg #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RST = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] WMASK = {WIDTH{1'b1}}
) (
  input wire clk_sys,
  input wire reset_n,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  input wire [WIDTH-1:0] lane_mask,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] val_ff;
  wire [WIDTH-1:0] wr_bits;

  // reserved bits never take a write, so they keep their reset value
  assign wr_bits = WMASK & lane_mask;
  assign q = val_ff;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      val_ff <= RST;
    end else if (wr_en) begin
      val_ff <= (val_ff & ~wr_bits) | (wr_data & wr_bits);
    end
  end
endmodule

// file: cism_edge_latch.v
`timescale 1ns/10ps
// sticky event flags set on source edges, cleared by writing one
module cism_edge_latch #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] IMPL = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] BOTH = {WIDTH{1'b1}}
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [WIDTH-1:0] live,
  input wire [WIDTH-1:0] clr,
  output wire [WIDTH-1:0] flags
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      if (IMPL[i]) begin : g_impl
        reg prev_ff;
        reg flag_ff;
        wire rise;
        wire fall;
        wire hit;
        assign rise = live[i] & ~prev_ff;
        assign fall = ~live[i] & prev_ff;
        // rising-only sources ignore the falling edge
        assign hit = rise | (BOTH[i] & fall);
        assign flags[i] = flag_ff;
        always @(posedge clk_sys or negedge reset_n) begin
          if (!reset_n) begin
            prev_ff <= 1'b0;
            flag_ff <= 1'b0;
          end else begin
            prev_ff <= live[i];
            // a new edge beats a clear in the same cycle
            flag_ff <= hit | (flag_ff & ~clr[i]);
          end
        end
      end else begin : g_none
        assign flags[i] = 1'b0;
      end
    end
  endgenerate
endmodule

// file: cism_top.v
// Contract
// - mic-detect bit 1 and thermal-shutdown bit 0 flags latch on both edges
// - writing one clears a latched flag, writing zero leaves it alone
// - live bit 0 is one while die is above shutdown threshold
// - live bit 15 is one while temperature is above warning level
// - live bit 14 is one once the offset servo has completed
// - live bit 12 is one while the core fifo reports an error
// - live bits 11 and 9 show range controller signal detect, port2 and port1
// - mask1 holds pin masks 10,9,8,7,0 and jack mask 5; zero unmasks
// - mask1 reserved bits 6 and 4..1 reset to one and never change
// - mask2 bit 15 masks thermal warning, reset one
// - mask2 bit 14 masks servo completion, reset one
// - mask2 bit 12 masks core fifo error, reset one
// - mask2 bits 11 and 9 mask range controller activity, reset one
// - mask2 bits 8,7 mask rate converter lock, 6,5 loop lock, reset one
// - core fifo error flag latches on its rising edge only
// - control bit 0 gates the combined request output, resets to zero
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "cism_map.vh"
module cism_top #(
  parameter ADDR_W = 16
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [ADDR_W-1:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output wire wb_ack_o,
  output wire irq,
  input wire pin11_live,
  input wire pin10_live,
  input wire pin9_live,
  input wire pin8_live,
  input wire jack_insert_live,
  input wire pin1_live,
  input wire thermal_warning_live,
  input wire offset_servo_done_live,
  input wire core_fifo_error_live,
  input wire port2_range_ctrl_signal_live,
  input wire port1_range_ctrl_signal_live,
  input wire rate_conv2_lock_live,
  input wire rate_conv1_lock_live,
  input wire freq_loop2_lock_live,
  input wire freq_loop1_lock_live,
  input wire mic_detect_live,
  input wire thermal_shutdown_live
);

  // register select codes
  localparam [5:0] SEL_NONE = 6'h00;
  localparam [5:0] SEL_FLAGS1 = 6'h01;
  localparam [5:0] SEL_FLAGS2 = 6'h02;
  localparam [5:0] SEL_LIVE2 = 6'h04;
  localparam [5:0] SEL_MASK1 = 6'h08;
  localparam [5:0] SEL_MASK2 = 6'h10;
  localparam [5:0] SEL_CTRL = 6'h20;

  // bus side flops and their next values
  reg ack_ff;
  reg [31:0] rdata_ff;
  reg nxt_ack;
  reg [31:0] nxt_rdata;

  // sampled sources and the request output
  reg irq_ff;
  reg [15:0] live1_ff;
  reg [15:0] live2_ff;
  reg [15:0] nxt_live1;
  reg [15:0] nxt_live2;
  reg nxt_irq;

  // bus decode
  wire req;
  wire take;
  wire wr_stb;
  wire [5:0] sel;
  wire [15:0] lane_mask;
  wire [15:0] wdata;

  // one write strobe per register except the live register
  wire hit_flags1;
  wire hit_flags2;
  wire hit_mask1;
  wire hit_mask2;
  wire hit_ctrl;

  // register contents and flag state
  wire [15:0] flags1;
  wire [15:0] flags2;
  wire [15:0] clr1;
  wire [15:0] clr2;
  wire [15:0] mask1;
  wire [15:0] mask2;
  wire [15:0] ctrl;
  wire [15:0] live_view;

  // events that would raise the request
  wire [15:0] pend1;
  wire [15:0] pend2;
  wire any_pend;

  // address decode, shared by the read path and the write path
  function [5:0] cism_decode;
    input [ADDR_W-1:0] adr;
    reg [13:0] idx;
    begin
      idx = adr[15:2];
      cism_decode = SEL_NONE;
      if (adr[1:0] == 2'b00) begin
        case (idx)
          `CISM_IDX_FLAGS1: cism_decode = SEL_FLAGS1;
          `CISM_IDX_FLAGS2: cism_decode = SEL_FLAGS2;
          `CISM_IDX_LIVE2: cism_decode = SEL_LIVE2;
          `CISM_IDX_MASK1: cism_decode = SEL_MASK1;
          `CISM_IDX_MASK2: cism_decode = SEL_MASK2;
          `CISM_IDX_CTRL: cism_decode = SEL_CTRL;
          default: cism_decode = SEL_NONE;
        endcase
      end
    end
  endfunction

  // write-one-to-clear vector; a zero bit or a closed byte lane
  // leaves its flag alone
  function [15:0] cism_clear;
    input hit;
    input [15:0] data;
    input [15:0] lanes;
    begin
      cism_clear = 16'h0000;
      if (hit) begin
        cism_clear = data & lanes;
      end
    end
  endfunction

  // bus handshake; a request is taken while ack is low,
  // and writes land on the edge the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign take = req & ~ack_ff;
  assign wr_stb = req & wb_we_i & ack_ff;
  assign sel = cism_decode(wb_adr_i);
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i[15:0];

  // the live register and unmapped addresses get no strobe,
  // so writes there are dropped
  assign hit_flags1 = wr_stb & (sel == SEL_FLAGS1);
  assign hit_flags2 = wr_stb & (sel == SEL_FLAGS2);
  assign hit_mask1 = wr_stb & (sel == SEL_MASK1);
  assign hit_mask2 = wr_stb & (sel == SEL_MASK2);
  assign hit_ctrl = wr_stb & (sel == SEL_CTRL);

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign irq = irq_ff;

  // clear strobes for the two flag registers
  assign clr1 = cism_clear(hit_flags1, wdata, lane_mask);
  assign clr2 = cism_clear(hit_flags2, wdata, lane_mask);

  // gather the first group of sources into register positions
  always @* begin
    nxt_live1 = 16'h0000;
    nxt_live1[`CISM_B1_PIN11] = pin11_live;
    nxt_live1[`CISM_B1_PIN10] = pin10_live;
    nxt_live1[`CISM_B1_PIN9] = pin9_live;
    nxt_live1[`CISM_B1_PIN8] = pin8_live;
    nxt_live1[`CISM_B1_JACK] = jack_insert_live;
    nxt_live1[`CISM_B1_PIN1] = pin1_live;
  end

  // gather the second group of sources into register positions
  always @* begin
    nxt_live2 = 16'h0000;
    nxt_live2[`CISM_B2_TWARN] = thermal_warning_live;
    nxt_live2[`CISM_B2_SERVO] = offset_servo_done_live;
    nxt_live2[`CISM_B2_FIFO] = core_fifo_error_live;
    nxt_live2[`CISM_B2_DRC2] = port2_range_ctrl_signal_live;
    nxt_live2[`CISM_B2_DRC1] = port1_range_ctrl_signal_live;
    nxt_live2[`CISM_B2_SRC2] = rate_conv2_lock_live;
    nxt_live2[`CISM_B2_SRC1] = rate_conv1_lock_live;
    nxt_live2[`CISM_B2_FLL2] = freq_loop2_lock_live;
    nxt_live2[`CISM_B2_FLL1] = freq_loop1_lock_live;
    nxt_live2[`CISM_B2_MIC] = mic_detect_live;
    nxt_live2[`CISM_B2_TSHUT] = thermal_shutdown_live;
  end

  // one sampling stage so readback and edge logic see the same level;
  // the first group has no live readback, only its edges matter
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      live1_ff <= 16'h0000;
    end else begin
      live1_ff <= nxt_live1;
    end
  end

  // second group; cleared to zero, so a source already high at
  // release shows up as a rising edge two cycles later
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      live2_ff <= 16'h0000;
    end else begin
      live2_ff <= nxt_live2;
    end
  end

  // mic detect has no live readback bit; only the listed bits show
  assign live_view = live2_ff & `CISM_LIVE2_IMPL;

  // first event group, every source on both edges
  cism_edge_latch #(
    .WIDTH(16),
    .IMPL(`CISM_FLAGS1_IMPL),
    .BOTH(`CISM_FLAGS1_BOTH)
  ) u_flags1 (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .live(live1_ff),
    .clr(clr1),
    .flags(flags1)
  );

  // second event group, servo, fifo and activity on rising edge only
  cism_edge_latch #(
    .WIDTH(16),
    .IMPL(`CISM_FLAGS2_IMPL),
    .BOTH(`CISM_FLAGS2_BOTH)
  ) u_flags2 (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .live(live2_ff),
    .clr(clr2),
    .flags(flags2)
  );

  // first mask register; reserved bits fixed at one
  cism_field_reg #(
    .WIDTH(16),
    .RST(`CISM_MASK1_RST),
    .WMASK(`CISM_MASK1_WR)
  ) u_mask1 (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(hit_mask1),
    .wr_data(wdata),
    .lane_mask(lane_mask),
    .q(mask1)
  );

  // second mask register; everything masked out of reset
  cism_field_reg #(
    .WIDTH(16),
    .RST(`CISM_MASK2_RST),
    .WMASK(`CISM_MASK2_WR)
  ) u_mask2 (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(hit_mask2),
    .wr_data(wdata),
    .lane_mask(lane_mask),
    .q(mask2)
  );

  // combined request gate, open out of reset
  cism_field_reg #(
    .WIDTH(16),
    .RST(`CISM_CTRL_RST),
    .WMASK(`CISM_CTRL_WR)
  ) u_ctrl (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(hit_ctrl),
    .wr_data(wdata),
    .lane_mask(lane_mask),
    .q(ctrl)
  );

  // read mux; unmapped addresses still ack and return zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (sel)
      SEL_FLAGS1: nxt_rdata = {16'h0000, flags1};
      SEL_FLAGS2: nxt_rdata = {16'h0000, flags2};
      SEL_LIVE2: nxt_rdata = {16'h0000, live_view};
      SEL_MASK1: nxt_rdata = {16'h0000, mask1};
      SEL_MASK2: nxt_rdata = {16'h0000, mask2};
      SEL_CTRL: nxt_rdata = {16'h0000, ctrl};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // each request is answered once; a master that keeps stb up
  // past ack starts a fresh request, it is not acked twice in a row
  always @* begin
    nxt_ack = 1'b0;
    if (take) begin
      nxt_ack = 1'b1;
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // data is captured with the take, so it stands unchanged in the
  // ack cycle whatever the sources do meanwhile
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (take) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // masks only decide what is pending, flags latch regardless;
  // reserved mask1 bits have no flag behind them
  assign pend1 = flags1 & ~mask1 & `CISM_MASK1_WR;
  assign pend2 = flags2 & ~mask2;
  assign any_pend = |{pend1, pend2};

  // the control gate sits after the pending logic;
  // registered so the pin never glitches on decode
  always @* begin
    nxt_irq = any_pend & ~ctrl[`CISM_BC_REQ_MASK];
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

endmodule

// file: cism_top_monitor.sv
`timescale 1ns/10ps
// bus handshake, readback and request gating seen from the top ports
module cism_top_monitor #(
  parameter ADDR_W = 16
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [ADDR_W-1:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire irq,
  input wire thermal_warning_live,
  input wire thermal_shutdown_live
);
  // read data is only meaningful in the ack cycle
  wire rd = wb_ack_o && !wb_we_i;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  mask1_rsvd_a: assert property (
    rd && wb_adr_i == 16'h1ce0 |-> wb_dat_o[6] && wb_dat_o[4:1] == 4'hf)
    else $error("reserved mask bits not one");
  mask2_unused_a: assert property (
    rd && wb_adr_i == 16'h1ce4 |-> (wb_dat_o[15:0] & 16'h241c) == 16'h0000)
    else $error("unused mask bits set");
  live_warn_a: assert property (rd && wb_adr_i == 16'h1cc8 && $stable(thermal_warning_live)
    && $past(thermal_warning_live, 2) == thermal_warning_live
    && $past(thermal_warning_live, 3) == thermal_warning_live |-> wb_dat_o[15] == thermal_warning_live)
    else $error("warning live bit wrong");
  live_shut_a: assert property (rd && wb_adr_i == 16'h1cc8 && $stable(thermal_shutdown_live)
    && $past(thermal_shutdown_live, 2) == thermal_shutdown_live
    && $past(thermal_shutdown_live, 3) == thermal_shutdown_live |-> wb_dat_o[0] == thermal_shutdown_live)
    else $error("shutdown live bit wrong");
  req_gate_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[0]
    && wb_adr_i == 16'h1d00 |-> ##2 !irq)
    else $error("request not gated by control");
  unmapped_a: assert property (rd && wb_adr_i == 16'h1cfc |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

bind cism_top cism_top_monitor #(.ADDR_W(ADDR_W)) mon (.clk_sys, .reset_n, .wb_adr_i, .wb_dat_i,
  .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq, .thermal_warning_live,
  .thermal_shutdown_live);

// file: cism_top_bench.sv
`timescale 1ns/10ps
module cism_top_bench;
  localparam logic [15:0] F1 = 16'h1cc0;
  localparam logic [15:0] F2 = 16'h1cc4;
  localparam logic [15:0] LV = 16'h1cc8;
  localparam logic [15:0] M1 = 16'h1ce0;
  localparam logic [15:0] M2 = 16'h1ce4;
  localparam logic [15:0] CT = 16'h1d00;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h3;
  logic [15:0] adr = 16'h0000;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] got;
  logic ack;
  logic irq;
  logic [15:0] s1 = 16'h0000;
  logic [15:0] s2 = 16'h0000;
  int err_count = 0;
  int samples_checked = 0;
  // sources sit at their flag positions so expected words read straight off
  cism_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_ack_o(ack), .irq(irq), .pin11_live(s1[10]), .pin10_live(s1[9]), .pin9_live(s1[8]),
    .pin8_live(s1[7]), .jack_insert_live(s1[5]), .pin1_live(s1[0]),
    .thermal_warning_live(s2[15]), .offset_servo_done_live(s2[14]), .core_fifo_error_live(s2[12]),
    .port2_range_ctrl_signal_live(s2[11]), .port1_range_ctrl_signal_live(s2[9]),
    .rate_conv2_lock_live(s2[8]), .rate_conv1_lock_live(s2[7]), .freq_loop2_lock_live(s2[6]),
    .freq_loop1_lock_live(s2[5]), .mic_detect_live(s2[1]), .thermal_shutdown_live(s2[0]));
  initial forever #25 clk_sys = ~clk_sys;
  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_count++;
      complete_run();
    end
    got = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, 4'h3);
    chk($sformatf("reg %h", a), got, e);
  endtask
  // source to irq takes three edges, four leaves margin
  task automatic settle;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic do_reset(input int n);
    reset_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask
  task automatic t_regs;
    rd(F2, 32'h0);
    rd(M1, 32'h07ff);
    rd(M2, 32'hdbe3);
    rd(CT, 32'h0);
    rd(16'h1cfc, 32'h0);
    wr(M1, 32'h0);
    rd(M1, 32'h005e);
    wr(M2, 32'h0);
    rd(M2, 32'h0);
    wr(LV, 32'hffff);
    rd(LV, 32'h0);
    wr(M1, 32'h07ff);
    wr(M2, 32'hdbe3);
  endtask
  task automatic t_edges;
    s2 <= 16'h0003;
    settle;
    rd(LV, 32'h0001);
    rd(F2, 32'h0003);
    wr(F2, 32'h0);
    bus(1'b1, F2, 32'h0003, 4'h2);
    rd(F2, 32'h0003);
    wr(F2, 32'h0001);
    rd(F2, 32'h0002);
    s2 <= 16'h0000;
    settle;
    rd(F2, 32'h0003);
    wr(F2, 32'hffff);
  endtask
  task automatic t_live;
    s2 <= 16'hdbe0;
    settle;
    rd(LV, 32'hdbe0);
    rd(F2, 32'hdbe0);
    wr(F2, 32'hffff);
    s2 <= 16'h0000;
    settle;
    rd(F2, 32'h81e0);
    wr(F2, 32'hffff);
  endtask
  // every event: masked latch, unmask, gate, hold, clear
  task automatic t_irq;
    logic [31:0] b;
    for (int i = 0; i < 32; i++) begin
      b = 32'h1 << i;
      if ((b & 32'h07a1dbe3) != 0) begin
        {s1, s2} <= b;
        settle;
        chk("irq masked", irq, 32'h0);
        if (i < 16)
          wr(M2, 32'hdbe3 & ~b);
        else
          wr(M1, 32'h07ff & ~(b >> 16)); // reserved bits kept at one
        settle;
        chk("irq open", irq, 32'h1);
        wr(CT, 32'h1);
        settle;
        chk("irq gated", irq, 32'h0);
        wr(CT, 32'h0);
        {s1, s2} <= 32'h0;
        settle;
        chk("irq held", irq, 32'h1);
        wr(F1, 32'hffff);
        wr(F2, 32'hffff);
        settle;
        chk("irq cleared", irq, 32'h0);
        wr(M1, 32'h07ff);
        wr(M2, 32'hdbe3);
      end
    end
  endtask
  initial begin
    do_reset(12);
    t_regs;
    t_edges;
    t_live;
    t_irq;
    do_reset(2);
    t_regs;
    complete_run;
  end
endmodule
